// File: hw/ulm_pkg.sv
// Shared constants and types for the UART line, modem and RS-485 status slice
package ulm_pkg;

  // Register map, byte addresses on the AXI4-Lite slave
  localparam int        AXI_AW           = 8;
  localparam logic [7:0] OFF_RX_HOLD     = 8'h00;
  localparam logic [7:0] OFF_LINE_STATUS = 8'h04;
  localparam logic [7:0] OFF_MODEM_STAT  = 8'h08;
  localparam logic [7:0] OFF_SCRATCH     = 8'h0c;
  localparam logic [7:0] OFF_FEATURE     = 8'h10;
  localparam logic [7:0] OFF_MODEM_CTRL  = 8'h14;
  localparam logic [7:0] OFF_ENH_FEAT    = 8'h18;
  localparam logic [7:0] OFF_INT_EN      = 8'h1c;

  // Reset values
  localparam logic [7:0] SCRATCH_RST  = 8'hff;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [5:0] PIN_SYNC_RST = 6'h1f;

  // Field positions
  localparam int MCR_DTR   = 0;
  localparam int MCR_RTS   = 1;
  localparam int MCR_FSEL  = 2;
  localparam int MCR_OP2   = 3;
  localparam int MCR_LOOP  = 4;
  localparam int EFR_ENH   = 4;
  localparam int EFR_AUTOF = 6;
  localparam int IER_TX    = 1;
  localparam int IER_MS    = 3;
  localparam int FCT_IRINV = 4;
  localparam int FCT_R485  = 5;
  localparam int MS_NINE   = 0;
  localparam int MS_RXDIS  = 2;
  localparam int MS_TXDIS  = 3;
  localparam int MS_TURN_L = 4;

  // Receive FIFO entry: break, framing, parity, data
  localparam int FIFO_DEPTH = 32;
  localparam int ENTRY_W    = 11;
  localparam int ENT_PE     = 8;
  localparam int ENT_FE     = 9;
  localparam int ENT_BRK    = 10;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Direction control states
  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_SEND = 3'b010,
    RS_TURN = 3'b100
  } ulm_rs_state_t;

endpackage

// File: hw/ulm_fifo_if.sv
// Carrier between the slice and its receive FIFO
`timescale 1ns/10ps
`default_nettype none
interface ulm_fifo_if #(parameter int W = 11);
  logic         push;
  logic [W-1:0] wdata;
  logic         pop;
  logic [W-1:0] rdata;
  logic         empty;
  logic         full;
  logic         err_any;

  modport store (input push, wdata, pop, output rdata, empty, full, err_any);
  modport user  (output push, wdata, pop, input rdata, empty, full, err_any);
endinterface
`default_nettype wire

// File: hw/ulm_rx_fifo.sv
// Receive FIFO holding each character with its own error flags
`timescale 1ns/10ps
`default_nettype none
module ulm_rx_fifo
  import ulm_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  ulm_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);

  logic [ENTRY_W-1:0] mem [DEPTH];
  logic [AW-1:0]      wr_ptr_reg;
  logic [AW-1:0]      rd_ptr_reg;
  logic [AW:0]        count_reg;
  logic [AW:0]        err_cnt_reg;

  // A push into a full FIFO is dropped so stored characters stay intact,
  // unless a pop frees a slot in the same cycle
  wire do_push  = f.push & (~f.full | f.pop);
  wire do_pop   = f.pop & ~f.empty;
  wire push_err = |f.wdata[ENT_BRK:ENT_PE];
  wire pop_err  = |f.rdata[ENT_BRK:ENT_PE];

  assign f.rdata   = mem[rd_ptr_reg];
  assign f.empty   = (count_reg == '0);
  assign f.full    = (count_reg == (AW+1)'(DEPTH));
  assign f.err_any = (err_cnt_reg != '0);

  // Storage has no reset; rdata shows the slot at the read pointer even while the FIFO is empty
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= f.wdata;
    end
  end

  // Pointers, fill level and count of entries carrying an error
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      count_reg   <= '0;
      err_cnt_reg <= '0;
    end else begin
      wr_ptr_reg  <= wr_ptr_reg + AW'(do_push);
      rd_ptr_reg  <= rd_ptr_reg + AW'(do_pop);
      count_reg   <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
      err_cnt_reg <= err_cnt_reg + (AW+1)'(do_push & push_err) - (AW+1)'(do_pop & pop_err);
    end
  end
endmodule
`default_nettype wire

// File: hw/ulm_top.sv
// UART line status, modem status, flow control and RS-485 direction slice
// Operation
// - Line low a whole frame sets break, one break entry queued, held until line high.
// - Framing error flag belongs to the character at the receive holding position.
// - Parity error flag follows whichever character is currently readable.
// - Character completing with FIFO full sets overrun and is discarded.
// - Data-ready is high while any received character waits.
// - Carrier and ring status invert their pins; loopback uses control bits 3 and 2.
// - Data-set-ready status inverts its pin; loopback uses terminal-ready control bit.
// - Clear-to-send status inverts its pin; loopback uses request-to-send control bit.
// - Auto flow watches clear-to-send or data-set-ready; high stops, low resumes transmission.
// - Carrier, set-ready and clear-to-send changes set deltas and modem interrupt if enabled.
// - Ring delta sets only when ringing ends, raising modem interrupt if enabled.
// - Write-only field 7:4 sets turnaround delay of 0 to 15 bit times.
// - Turnaround field is writable only with enhanced functions enabled.
// - Transmitter disable halts sending and keeps queued bytes until cleared.
// - Receiver disable still takes one whole character, then nothing more.
// - Re-enabling the receiver on an idle line receives the next character normally.
// - Receive FIFO stays readable whether the receiver is enabled or not.
// - Write-only bit 0 selects 8-bit or 9-bit multidrop mode.
// - Scratch register is 8 bits and resets to all ones.
// - Auto RS-485 raises request-to-send on load, drops it after last stop plus delay.
// - Transmit interrupt uses shifter empty with auto RS-485, holding empty otherwise.
// - Feature bit 4 inverts the infrared receive input.
// - Loopback enable bit selects local loopback and is clear after reset.
`timescale 1ns/10ps
`default_nettype none
module ulm_top
  import ulm_pkg::*;
#(
  parameter int RX_DEPTH = FIFO_DEPTH
) (
  input  wire logic              CLK_SYS,
  input  wire logic              NRST,
  input  wire logic [AXI_AW-1:0] AWADDR,
  input  wire logic              AWVALID,
  output var  logic              AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output var  logic              WREADY,
  output var  logic [1:0]        BRESP,
  output var  logic              BVALID,
  input  wire logic              BREADY,
  input  wire logic [AXI_AW-1:0] ARADDR,
  input  wire logic              ARVALID,
  output var  logic              ARREADY,
  output var  logic [31:0]       RDATA,
  output var  logic [1:0]        RRESP,
  output var  logic              RVALID,
  input  wire logic              RREADY,
  input  wire logic              CD_N,
  input  wire logic              RI_N,
  input  wire logic              DSR_N,
  input  wire logic              CTS_N,
  input  wire logic              RX_IN,
  input  wire logic              IR_RX,
  input  wire logic              RX_CHAR_DONE,
  input  wire logic [7:0]        RX_CHAR,
  input  wire logic              RX_PAR_ERR,
  input  wire logic              RX_FRM_ERR,
  input  wire logic              RX_BREAK_DONE,
  input  wire logic              TX_LOAD,
  input  wire logic              TX_HOLD_EMPTY,
  input  wire logic              TX_SHIFT_EMPTY,
  input  wire logic              BIT_TICK,
  output var  logic              TX_ENABLE,
  output var  logic              RX_ENABLE,
  output var  logic              RTS_N,
  output var  logic              DTR_N,
  output var  logic              IR_RX_DATA,
  output var  logic              NINE_BIT_MODE,
  output var  logic              TX_INT,
  output var  logic              MS_INT
);
  ulm_fifo_if #(.W(ENTRY_W)) fifo ();

  ulm_rx_fifo #(.DEPTH(RX_DEPTH)) u_rx_fifo (
    .clk  (CLK_SYS),
    .nrst (NRST),
    .f    (fifo.store)
  );

  // Word decode shared by both bus channels
  function automatic logic hit(input logic [AXI_AW-1:0] a, input logic [7:0] off);
    return a[AXI_AW-1:2] == off[AXI_AW-1:2];
  endfunction

  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    return a[AXI_AW-1:5] == '0;
  endfunction

  logic [5:0]        pin_meta_reg;
  logic [5:0]        pin_sync_reg;
  logic              awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic              aw_held_reg, w_held_reg, w_strb_reg;
  logic [AXI_AW-1:0] aw_addr_reg;
  logic [7:0]        w_data_reg;
  logic [1:0]        bresp_reg, rresp_reg;
  logic [31:0]       rdata_reg;
  logic [7:0]        scratch_reg, feature_control_reg, mcr_reg, efr_reg, ier_reg;
  logic [3:0]        turn_reg;
  logic              tx_dis_reg, rx_dis_reg, nine_reg, rx_credit_reg;
  logic              brk_reg, ovr_reg;
  logic [3:0]        prev_st_reg, delta_reg;
  ulm_rs_state_t     rs_state_reg, rs_state_next;
  logic [3:0]        turn_cnt_reg;
  logic              rts_n_reg, dtr_n_reg, tx_en_reg, rx_en_reg;
  logic              ir_reg, tx_int_reg, ms_int_reg;

  // Synchronised pins; only the second stage is looked at
  wire cd_n_s  = pin_sync_reg[0];
  wire ri_n_s  = pin_sync_reg[1];
  wire dsr_n_s = pin_sync_reg[2];
  wire cts_n_s = pin_sync_reg[3];
  wire rx_s    = pin_sync_reg[4];
  wire ir_s    = pin_sync_reg[5];

  // Bus handshakes
  wire rd_fire = ARVALID & arready_reg;
  wire wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire wr_en   = wr_fire & w_strb_reg;

  // Write targets
  wire wr_scr  = wr_en & hit(aw_addr_reg, OFF_SCRATCH);
  wire wr_fct  = wr_en & hit(aw_addr_reg, OFF_FEATURE);
  wire wr_mcr  = wr_en & hit(aw_addr_reg, OFF_MODEM_CTRL);
  wire wr_efr  = wr_en & hit(aw_addr_reg, OFF_ENH_FEAT);
  wire wr_ier  = wr_en & hit(aw_addr_reg, OFF_INT_EN);
  wire wr_msw  = wr_en & hit(aw_addr_reg, OFF_MODEM_STAT);
  wire wr_enh  = wr_msw & efr_reg[EFR_ENH];

  // Read side effects
  wire rd_rhr  = rd_fire & hit(ARADDR, OFF_RX_HOLD);
  wire rd_lsr  = rd_fire & hit(ARADDR, OFF_LINE_STATUS);
  wire rd_msr  = rd_fire & hit(ARADDR, OFF_MODEM_STAT);

  // Modem status, pins or loopback controls
  wire loop   = mcr_reg[MCR_LOOP];
  wire cd_st  = loop ? mcr_reg[MCR_OP2]  : ~cd_n_s;
  wire ri_st  = loop ? mcr_reg[MCR_FSEL] : ~ri_n_s;
  wire dsr_st = loop ? mcr_reg[MCR_DTR]  : ~dsr_n_s;
  wire cts_st = loop ? mcr_reg[MCR_RTS]  : ~cts_n_s;
  wire [3:0] cur_st = {cd_st, ri_st, dsr_st, cts_st};

  // Change detect; ring only counts when ringing ends (status 1 to 0)
  wire [3:0] delta_set = {cd_st ^ prev_st_reg[3],
                          prev_st_reg[2] & ~ri_st,
                          dsr_st ^ prev_st_reg[1],
                          cts_st ^ prev_st_reg[0]};
  wire [3:0] delta_next = (delta_reg & ~{4{rd_msr}}) | delta_set;

  // Receiver acceptance: enabled, or the one character owed after disable
  wire rx_take    = ~rx_dis_reg | rx_credit_reg;
  wire brk_new    = RX_BREAK_DONE & ~brk_reg & rx_take;
  wire char_in    = (RX_CHAR_DONE & rx_take) | brk_new;
  wire ovr_set    = char_in & fifo.full & ~rd_rhr;

  assign fifo.push  = char_in;
  assign fifo.pop   = rd_rhr;
  assign fifo.wdata = brk_new ? {1'b1, 10'h000}
                              : {1'b0, RX_FRM_ERR, RX_PAR_ERR, RX_CHAR};

  // Line status assembled from the readable entry
  wire top_fe = ~fifo.empty & fifo.rdata[ENT_FE];
  wire top_pe = ~fifo.empty & fifo.rdata[ENT_PE];
  wire [7:0] lsr_val = {fifo.err_any, TX_HOLD_EMPTY & TX_SHIFT_EMPTY, TX_HOLD_EMPTY,
                        brk_reg, top_fe, top_pe, ovr_reg, ~fifo.empty};
  wire [7:0] msr_val = {cur_st, delta_reg};

  // Read multiplexer; write-only fields share the modem status word and read back as modem status, unmapped words read zero
  wire [7:0] rd_mux =
    hit(ARADDR, OFF_RX_HOLD)     ? fifo.rdata[7:0] :
    hit(ARADDR, OFF_LINE_STATUS) ? lsr_val :
    hit(ARADDR, OFF_MODEM_STAT)  ? msr_val :
    hit(ARADDR, OFF_SCRATCH)     ? scratch_reg :
    hit(ARADDR, OFF_FEATURE)     ? feature_control_reg :
    hit(ARADDR, OFF_MODEM_CTRL)  ? mcr_reg :
    hit(ARADDR, OFF_ENH_FEAT)    ? efr_reg :
    hit(ARADDR, OFF_INT_EN)      ? ier_reg : 8'h00;

  // Flow stop watches the selected handshake pin
  wire flow_stop = efr_reg[EFR_AUTOF] &
                   (mcr_reg[MCR_FSEL] ? dsr_n_s : cts_n_s);
  wire tx_done   = TX_SHIFT_EMPTY & TX_HOLD_EMPTY & ~TX_LOAD;

  // Two-stage synchroniser for every pin input
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      pin_meta_reg <= PIN_SYNC_RST;
      pin_sync_reg <= PIN_SYNC_RST;
    end else begin
      pin_meta_reg <= {IR_RX, RX_IN, CTS_N, DSR_N, RI_N, CD_N};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // AXI write channels; address and data may arrive in either order
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (AWVALID & awready_reg) begin
        aw_addr_reg <= AWADDR;
        aw_held_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (WVALID & wready_reg) begin
        w_data_reg <= WDATA[7:0];
        w_strb_reg <= WSTRB[0];
        w_held_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg & BREADY) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // AXI read channel; data is captured on the address handshake
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else if (rd_fire) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= {24'h00_0000, rd_mux};
      rresp_reg   <= mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg & RREADY) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Software registers; the turnaround field is locked unless enhanced mode is on
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      scratch_reg <= SCRATCH_RST;
      feature_control_reg    <= CTRL_RST;
      mcr_reg     <= CTRL_RST;
      efr_reg     <= CTRL_RST;
      ier_reg     <= CTRL_RST;
      turn_reg    <= 4'h0;
      tx_dis_reg  <= 1'b0;
      rx_dis_reg  <= 1'b0;
      nine_reg    <= 1'b0;
    end else begin
      if (wr_scr) scratch_reg <= w_data_reg;
      if (wr_fct) feature_control_reg    <= {2'b00, w_data_reg[5:4], 4'h0};
      if (wr_mcr) mcr_reg     <= {3'b000, w_data_reg[4:0]};
      if (wr_efr) efr_reg     <= w_data_reg;
      if (wr_ier) ier_reg     <= w_data_reg;
      if (wr_enh) begin
        turn_reg   <= w_data_reg[7:MS_TURN_L];
        tx_dis_reg <= w_data_reg[MS_TXDIS];
        rx_dis_reg <= w_data_reg[MS_RXDIS];
      end
      if (wr_msw) nine_reg    <= w_data_reg[MS_NINE];
    end
  end

  // Receive flags; hardware sets win over clears in the same cycle
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rx_credit_reg <= 1'b0;
      brk_reg       <= 1'b0;
      ovr_reg       <= 1'b0;
      prev_st_reg   <= 4'h0;
      delta_reg     <= 4'h0;
    end else begin
      if (wr_enh & w_data_reg[MS_RXDIS] & ~rx_dis_reg) begin
        rx_credit_reg <= 1'b1;
      end else if (rx_dis_reg & char_in) begin
        rx_credit_reg <= 1'b0;
      end
      brk_reg     <= brk_new | (brk_reg & ~rx_s);
      ovr_reg     <= ovr_set | (ovr_reg & ~rd_lsr);
      prev_st_reg <= cur_st;
      delta_reg   <= delta_next;
    end
  end

  // Direction control state machine for auto RS-485
  always_comb begin
    rs_state_next = rs_state_reg;
    case (rs_state_reg)
      RS_IDLE: begin
        if (TX_LOAD) rs_state_next = RS_SEND;
      end
      RS_SEND: begin
        if (tx_done) rs_state_next = (turn_reg == 4'h0) ? RS_IDLE : RS_TURN;
      end
      RS_TURN: begin
        if (TX_LOAD) begin
          rs_state_next = RS_SEND;
        end else if (BIT_TICK & (turn_cnt_reg == 4'h1)) begin
          rs_state_next = RS_IDLE;
        end
      end
      default: rs_state_next = RS_IDLE;
    endcase
    if (!feature_control_reg[FCT_R485]) rs_state_next = RS_IDLE;
  end

  // Turnaround countdown in bit times after the last stop bit
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rs_state_reg <= RS_IDLE;
      turn_cnt_reg <= 4'h0;
    end else begin
      rs_state_reg <= rs_state_next;
      if (rs_state_reg != RS_TURN) begin
        turn_cnt_reg <= turn_reg;
      end else if (BIT_TICK) begin
        turn_cnt_reg <= turn_cnt_reg - 4'h1;
      end
    end
  end

  // Registered outputs; transmit disable and flow stop drop TX_ENABLE one clock later, receive disable after the owed character
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rts_n_reg  <= 1'b1;
      dtr_n_reg  <= 1'b1;
      tx_en_reg  <= 1'b1;
      rx_en_reg  <= 1'b1;
      ir_reg     <= 1'b0;
      tx_int_reg <= 1'b0;
      ms_int_reg <= 1'b0;
    end else begin
      rts_n_reg  <= feature_control_reg[FCT_R485] ? (rs_state_next != RS_IDLE)
                                       : ~mcr_reg[MCR_RTS];
      dtr_n_reg  <= ~mcr_reg[MCR_DTR];
      tx_en_reg  <= ~tx_dis_reg & ~flow_stop;
      rx_en_reg  <= ~rx_dis_reg | rx_credit_reg;
      ir_reg     <= ir_s ^ feature_control_reg[FCT_IRINV];
      tx_int_reg <= ier_reg[IER_TX] &
                    (feature_control_reg[FCT_R485] ? TX_SHIFT_EMPTY : TX_HOLD_EMPTY);
      ms_int_reg <= ier_reg[IER_MS] & (|delta_next);
    end
  end

  assign AWREADY       = awready_reg;
  assign WREADY        = wready_reg;
  assign BVALID        = bvalid_reg;
  assign BRESP         = bresp_reg;
  assign ARREADY       = arready_reg;
  assign RVALID        = rvalid_reg;
  assign RDATA         = rdata_reg;
  assign RRESP         = rresp_reg;
  assign RTS_N         = rts_n_reg;
  assign DTR_N         = dtr_n_reg;
  assign TX_ENABLE     = tx_en_reg;
  assign RX_ENABLE     = rx_en_reg;
  assign IR_RX_DATA    = ir_reg;
  assign NINE_BIT_MODE = nine_reg;
  assign TX_INT        = tx_int_reg;
  assign MS_INT        = ms_int_reg;

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  a_brk_holds_low: assert property (brk_reg && !rx_s |=> brk_reg)
    else $error("break flag dropped while line low");
  a_brk_clears: assert property (brk_reg && rx_s && !RX_BREAK_DONE |=> !brk_reg)
    else $error("break flag kept after line high");
  a_ovr_on_full: assert property (RX_CHAR_DONE && rx_take && fifo.full && !rd_rhr
                                  |=> ovr_reg && fifo.full)
    else $error("overrun missed or FIFO changed");
  a_ready_read: assert property (rd_lsr |=> RVALID && RDATA[0] == $past(!fifo.empty))
    else $error("data ready bit wrong");
  a_cts_status: assert property (rd_msr |=> RDATA[4] == $past(cts_st))
    else $error("clear-to-send status wrong");
  a_ring_delta: assert property (prev_st_reg[2] && !ri_st |=> delta_reg[2])
    else $error("ring end not flagged");
  a_cd_delta: assert property ($changed(cd_st) |=> delta_reg[3])
    else $error("carrier change not flagged");
  a_flow_stops: assert property (efr_reg[EFR_AUTOF] && !mcr_reg[MCR_FSEL] && cts_n_s
                                 |=> !TX_ENABLE)
    else $error("transmit not stopped by flow");
  a_tx_disable: assert property (tx_dis_reg |=> !TX_ENABLE)
    else $error("transmitter ran while disabled");
  a_turn_locked: assert property (wr_msw && !efr_reg[EFR_ENH] |=> $stable(turn_reg))
    else $error("turnaround written while locked");
  a_rts_turn: assert property (feature_control_reg[FCT_R485] && rs_state_reg == RS_TURN && !BIT_TICK
                               |=> RTS_N)
    else $error("direction dropped during turnaround");

  c_turn_done: cover property (rs_state_reg == RS_TURN ##1 rs_state_reg == RS_IDLE);
  c_overrun:   cover property (ovr_set);
  c_delta_rd:  cover property (rd_msr && |delta_reg);
  c_flow_stop: cover property (flow_stop && TX_LOAD);
endmodule
`default_nettype wire

// File: sim/ulm_modem_model.sv
// Far-side partner: modem pins, line level and infrared input
`timescale 1ns/10ps
`default_nettype none
module ulm_modem_model (
  input  wire logic       clk,
  input  wire logic [5:0] lvl,
  output var  logic [5:0] pins
);
  // Idle modem: all active-low pins high, line at mark, IR dark
  initial pins = 6'h3e;
  // Pins move just after the slice's own sampling edge, so the slice sees them one edge later
  always @(posedge clk) begin
    pins <= lvl;
  end
endmodule
`default_nettype wire

// File: sim/ulm_top_tb.sv
// Self-checking bench for the line, modem and RS-485 status slice
`timescale 1ns/10ps
`default_nettype none
module ulm_top_tb
  import ulm_pkg::*;
();
  logic        clk_sys = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, rx_done = 1'b0, pe = 1'b0, fe = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0, rx_char = 8'h0, wdata = 8'h0;
  logic [3:0]  strb = 4'hf, p;
  logic [5:0]  lvl = 6'h3e, pins;
  logic [31:0] rdata, d, x, e, seed = 32'h28;
  logic [1:0]  bresp, rresp, resp;
  logic        awready, wready, bvalid, arready, rvalid, tx_en, ir_data, nine, ms_int;
  logic        brk = 1'b0, txl = 1'b0, he = 1'b1, se = 1'b1, tick = 1'b0;
  logic        rts_n, dtr_n, rx_en, tx_int;
  int          failures = 0, num_checks = 0;

  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;

  ulm_top dut (
    .CLK_SYS(clk_sys), .NRST(nrst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA({24'h0, wdata}), .WSTRB(strb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .CD_N(pins[5]),
    .RI_N(pins[4]), .DSR_N(pins[3]), .CTS_N(pins[2]), .RX_IN(pins[1]), .IR_RX(pins[0]),
    .RX_CHAR_DONE(rx_done), .RX_CHAR(rx_char), .RX_PAR_ERR(pe), .RX_FRM_ERR(fe),
    .RX_BREAK_DONE(brk), .TX_LOAD(txl), .TX_HOLD_EMPTY(he), .TX_SHIFT_EMPTY(se),
    .BIT_TICK(tick), .TX_ENABLE(tx_en), .RX_ENABLE(rx_en), .RTS_N(rts_n), .DTR_N(dtr_n),
    .IR_RX_DATA(ir_data), .NINE_BIT_MODE(nine), .TX_INT(tx_int), .MS_INT(ms_int)
  );
  ulm_modem_model partner (.clk(clk_sys), .lvl(lvl), .pins(pins));

  // Bench helpers: random source, expectations, bus cycles, comparison
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Status high nibble is the inverted pins; ring delta only on end of ringing
  function automatic logic [31:0] msr_exp(input logic [3:0] o, input logic [3:0] n);
    return {24'h0, ~n, o[3] ^ n[3], ~o[2] & n[2], o[1] ^ n[1], o[0] ^ n[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      resp = bresp;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    rd(a);
    chk(d & m, v);
  endtask
  // One completed character from the receive engine, flags alongside
  task automatic push(input logic [7:0] c, input logic pp, input logic ff);
    @(posedge clk_sys);
    rx_char <= c;
    pe <= pp;
    fe <= ff;
    rx_done <= 1'b1;
    @(posedge clk_sys);
    rx_done <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence; a strobe-less write must not land
  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rc(OFF_SCRATCH, 32'hff, 32'hff);
    rc(OFF_LINE_STATUS, 32'h1f, 32'h0);
    repeat (4) begin
      x = xs();
      wr(OFF_SCRATCH, x[7:0]);
      strb <= 4'he;
      wr(OFF_SCRATCH, ~x[7:0]);
      strb <= 4'hf;
      rc(OFF_SCRATCH, 32'hff, {24'h0, x[7:0]});
    end
    wr(8'h20, 8'h1);
    chk(resp, RESP_SLVERR);
    wr(OFF_INT_EN, 8'h08);
    rd(OFF_MODEM_STAT);
    // Random pin patterns: settle past the synchronisers, then read
    repeat (6) begin
      x = xs();
      p = lvl[5:2];
      lvl[5:2] <= x[3:0];
      e = msr_exp(p, x[3:0]);
      repeat (5) @(posedge clk_sys);
      chk(ms_int, |e[3:0]);
      rc(OFF_MODEM_STAT, 32'hff, e);
      @(posedge clk_sys);
      chk(ms_int, 1'b0);
    end
    wr(OFF_ENH_FEAT, 8'h50);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_MODEM_CTRL, {5'h0, i[1], 2'h0});
      lvl[3:2] <= i[1] ? {i[0], ~i[0]} : {~i[0], i[0]};
      repeat (5) @(posedge clk_sys);
      chk(tx_en, !i[0]);
    end
    wr(OFF_ENH_FEAT, 8'h00);
    repeat (4) begin
      x = xs();
      wr(OFF_MODEM_CTRL, {4'h1, x[3:0]});
      rc(OFF_MODEM_STAT, 32'hf0, {24'h0, x[3], x[2], x[0], x[1], 4'h0});
      chk({rts_n, dtr_n}, {~x[1], ~x[0]});
    end
    wr(OFF_MODEM_CTRL, 8'h0);
    for (int i = 0; i < 2; i++) begin
      wr(OFF_ENH_FEAT, {3'h0, i[0], 4'h0});
      wr(OFF_MODEM_STAT, 8'h09);
      @(posedge clk_sys);
      chk(tx_en, !i[0]);
      chk(nine, 1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      wr(OFF_FEATURE, {3'h0, i[1], 4'h0});
      lvl[0] <= i[0];
      repeat (5) @(posedge clk_sys);
      chk(ir_data, i[0] ^ i[1]);
    end
    x = xs();
    push(x[7:0], 1'b1, 1'b0);
    push(x[15:8], 1'b0, 1'b1);
    rc(OFF_LINE_STATUS, 32'h0f, 32'h5);
    rc(OFF_RX_HOLD, 32'hff, {24'h0, x[7:0]});
    rc(OFF_LINE_STATUS, 32'h0f, 32'h9);
    rc(OFF_RX_HOLD, 32'hff, {24'h0, x[15:8]});
    for (int i = 0; i <= FIFO_DEPTH; i++) push(i[7:0], 1'b0, 1'b0);
    rc(OFF_LINE_STATUS, 32'h03, 32'h3);
    for (int i = 0; i < FIFO_DEPTH; i++) rc(OFF_RX_HOLD, 32'hff, i);
    wr(OFF_MODEM_STAT, 8'h04);
    push(8'ha5, 1'b0, 1'b0);
    push(8'h5a, 1'b0, 1'b0);
    rc(OFF_RX_HOLD, 32'hff, 32'ha5);
    rc(OFF_LINE_STATUS, 32'h01, 32'h0);
    chk({nine, rx_en}, 2'h0);
    wr(OFF_MODEM_STAT, 8'h00);
    push(8'h3c, 1'b0, 1'b0);
    rc(OFF_RX_HOLD, 32'hff, 32'h3c);
    // Break: line low first, so the flag is not cleared before the line is seen low
    lvl[1] <= 1'b0;
    repeat (5) @(posedge clk_sys);
    brk <= 1'b1;
    repeat (2) @(posedge clk_sys);
    brk <= 1'b0;
    rc(OFF_LINE_STATUS, 32'h91, 32'h91);
    rc(OFF_RX_HOLD, 32'hff, 32'h0);
    rc(OFF_LINE_STATUS, 32'h91, 32'h10);
    lvl[1] <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rc(OFF_LINE_STATUS, 32'h10, 32'h0);
    // Transmit interrupt source, then auto RS-485 with both turnaround end points
    wr(OFF_INT_EN, 8'h02);
    se <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(tx_int, 1'b1);
    wr(OFF_FEATURE, 8'h20);
    @(posedge clk_sys);
    chk({rts_n, tx_int}, 2'h0);
    for (int n = 0; n < 16; n += 5) begin
      wr(OFF_MODEM_STAT, {n[3:0], 4'h0});
      he <= 1'b0;
      se <= 1'b0;
      txl <= 1'b1;
      @(posedge clk_sys);
      txl <= 1'b0;
      he <= 1'b1;
      @(posedge clk_sys);
      chk({rts_n, tx_int}, 2'h2);
      se <= 1'b1;
      @(posedge clk_sys);
      repeat (n) begin
        @(posedge clk_sys);
        chk(rts_n, 1'b1);
        tick <= 1'b1;
        @(posedge clk_sys);
        tick <= 1'b0;
      end
      @(posedge clk_sys);
      chk(rts_n, 1'b0);
    end
    print_verdict();
  end

  // Watchdog, well past the fewer than a thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
